//--- hdl/pfes_consts.svh
`ifndef PFES_CONSTS_SVH
`define PFES_CONSTS_SVH
`define PFES_OFF_CTRL 12'h000
`define PFES_OFF_KEY 12'h004
`define PFES_OFF_PAGE 12'h008
`define PFES_OFF_OFFS 12'h00c
`define PFES_OFF_DATA 12'h010
`define PFES_OFF_STAT 12'h014
`define PFES_BIT_START 15
`define PFES_BIT_WRITE_ENABLE_BIT 14
`define PFES_BIT_ERASE 6
`define PFES_OP_ERASE 4'h2
`define PFES_OP_ROW 4'h1
`define PFES_KEY1 8'h55
`define PFES_KEY2 8'haa
`define PFES_ROW_WORDS 7'h40
`define PFES_BLK_ROWS 4'h8
`define PFES_ROW_TIME_NS 7000
`define PFES_ERASE_TIME_NS 4000
`define PFES_CLK_NS 100
`define PFES_ROW_CYC (`PFES_ROW_TIME_NS / `PFES_CLK_NS)
`define PFES_ERASE_CYC (`PFES_ERASE_TIME_NS / `PFES_CLK_NS)
`endif

//--- hdl/pfes_pkg.sv
package pfes_pkg;
	typedef enum logic [1:0] {PFES_IDLE, PFES_ERASE, PFES_ROW} pfes_state_t;
	typedef struct packed {
		logic [15:0] ctrl;
		logic [7:0] page;
		logic [15:0] offs;
	} pfes_regs_t;
endpackage

//--- hdl/pfes_buf.sv
`timescale 1ns/1ps
module pfes_buf (
	input wire logic pclk,
	input wire logic we,
	input wire logic [5:0] waddr,
	input wire logic [23:0] wdata,
	input wire logic [5:0] raddr,
	output logic [23:0] rdata
);
	logic [23:0] mem [0:63];

	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // pfes_buf

//--- hdl/pfes_seq.sv
`timescale 1ns/1ps
`include "pfes_consts.svh"
module pfes_seq
	import pfes_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cpu_stall,
	output logic flash_erase,
	output logic flash_prog,
	output logic [7:0] flash_page,
	output logic [15:0] flash_offs,
	output logic [5:0] flash_word,
	output logic flash_word_valid,
	output logic [23:0] flash_wdata
);
	pfes_regs_t regs, next_regs;
	pfes_state_t state, next_state;
	logic [1:0] key, next_key;
	logic [6:0] cnt, next_cnt;
	logic [5:0] widx, next_widx;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, next_stall, next_erase, next_prog;
	logic next_wv;
	logic [5:0] next_word;
	logic [23:0] buf_rdata;
	logic wr_acc, rd_setup, buf_we, start_ok;

	localparam int ER_LEN = `PFES_ERASE_CYC;
	localparam int RW_LEN = `PFES_ROW_CYC;

	default clocking cb_chk @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	function automatic logic is_off(input logic [11:0] a,
		input logic [11:0] o);
		is_off = (a == o);
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = is_off(a, `PFES_OFF_CTRL) || is_off(a, `PFES_OFF_KEY)
			|| is_off(a, `PFES_OFF_PAGE) || is_off(a, `PFES_OFF_OFFS)
			|| is_off(a, `PFES_OFF_DATA) || is_off(a, `PFES_OFF_STAT);
	endfunction

	assign rd_setup = psel && !penable && !pwrite;
	assign wr_acc = psel && penable && pwrite && pready;
	assign buf_we = wr_acc && is_off(paddr, `PFES_OFF_DATA);

	pfes_buf u_buf (
		.pclk(pclk),
		.we(buf_we),
		.waddr(widx),
		.wdata(pwdata[23:0]),
		.raddr(next_word),
		.rdata(buf_rdata)
	);

	// Start honoured only with fresh key pair and write enable
	assign start_ok = wr_acc && is_off(paddr, `PFES_OFF_CTRL)
		&& pwdata[`PFES_BIT_START] && pwdata[`PFES_BIT_WRITE_ENABLE_BIT]
		&& key == 2'h2 && state == PFES_IDLE;

	always_comb begin
		next_regs = regs;
		next_key = key;
		next_state = state;
		next_cnt = cnt;
		next_widx = widx;
		next_erase = 1'b0;
		next_prog = 1'b0;
		next_wv = 1'b0;
		next_word = flash_word;
		next_stall = cpu_stall;
		next_pready = psel && !penable;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		if (wr_acc) begin
			// Any other register write breaks the key sequence
			next_key = 2'h0;
			if (is_off(paddr, `PFES_OFF_KEY)) begin
				if (pwdata[7:0] == `PFES_KEY1) begin
					next_key = 2'h1;
				end else if (key == 2'h1 && pwdata[7:0] == `PFES_KEY2) begin
					next_key = 2'h2;
				end
			end else if (is_off(paddr, `PFES_OFF_CTRL)) begin
				// Start bit set only by an accepted start; busy
				// writes keep it so completion stays visible
				next_regs.ctrl = {start_ok || regs.ctrl[`PFES_BIT_START],
					pwdata[14:0]};
			end else if (is_off(paddr, `PFES_OFF_PAGE)) begin
				next_regs.page = pwdata[7:0];
			end else if (is_off(paddr, `PFES_OFF_OFFS)) begin
				next_regs.offs = pwdata[15:0];
			end else if (is_off(paddr, `PFES_OFF_DATA)) begin
				next_widx = widx + 6'h1;
			end
		end
		if (rd_setup) begin
			next_prdata = 32'h0;
			if (is_off(paddr, `PFES_OFF_CTRL)) begin
				next_prdata = {16'h0, regs.ctrl};
			end else if (is_off(paddr, `PFES_OFF_PAGE)) begin
				next_prdata = {24'h0, regs.page};
			end else if (is_off(paddr, `PFES_OFF_OFFS)) begin
				next_prdata = {16'h0, regs.offs};
			end else if (is_off(paddr, `PFES_OFF_STAT)) begin
				next_prdata = {24'h0, cpu_stall, state != PFES_IDLE, widx};
			end
		end
		// Error must stand with pready, so decode at setup for both ways
		if (psel && !penable && !is_mapped(paddr)) begin
			next_pslverr = 1'b1;
		end
		case (state)
		PFES_IDLE: begin
			if (start_ok) begin
				next_stall = 1'b1;
				next_cnt = 7'h0;
				next_word = 6'h0;
				if (pwdata[3:0] == `PFES_OP_ERASE
					&& pwdata[`PFES_BIT_ERASE]) begin
					next_state = PFES_ERASE;
					next_erase = 1'b1;
				end else if (pwdata[3:0] == `PFES_OP_ROW
					&& !pwdata[`PFES_BIT_ERASE]) begin
					next_state = PFES_ROW;
					next_prog = 1'b1;
				end else begin
					// Unknown op or erase bit not matching op: finish at once, memory untouched
					next_regs.ctrl[`PFES_BIT_START] = 1'b0;
					next_stall = 1'b0;
				end
			end
		end
		PFES_ERASE: begin
			next_cnt = cnt + 7'h1;
			if (cnt == 7'(`PFES_ERASE_CYC - 1)) begin
				next_state = PFES_IDLE;
				next_stall = 1'b0;
				next_regs.ctrl[`PFES_BIT_START] = 1'b0;
			end
		end
		PFES_ROW: begin
			// One row: 64 buffer words, one per cycle, then settle
			next_cnt = cnt + 7'h1;
			if (cnt < `PFES_ROW_WORDS) begin
				next_wv = 1'b1;
				next_word = cnt[5:0];
			end
			if (cnt == 7'(`PFES_ROW_CYC - 1)) begin
				next_state = PFES_IDLE;
				next_stall = 1'b0;
				next_widx = 6'h0;
				next_regs.ctrl[`PFES_BIT_START] = 1'b0;
			end
		end
		default: begin
			next_state = PFES_IDLE;
		end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs <= '0;
			state <= PFES_IDLE;
			key <= 2'h0;
			cnt <= 7'h0;
			widx <= 6'h0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			cpu_stall <= 1'b0;
			flash_erase <= 1'b0;
			flash_prog <= 1'b0;
			flash_word <= 6'h0;
			flash_word_valid <= 1'b0;
		end else begin
			regs <= next_regs;
			state <= next_state;
			key <= next_key;
			cnt <= next_cnt;
			widx <= next_widx;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			cpu_stall <= next_stall;
			flash_erase <= next_erase;
			flash_prog <= next_prog;
			flash_word <= next_word;
			flash_word_valid <= next_wv;
		end
	end

	assign flash_page = regs.page;
	assign flash_offs = regs.offs;
	assign flash_wdata = buf_rdata;

	sequence s_keyed_start;
		key == 2'h2 ##0 start_ok;
	endsequence

	sequence s_refused_start;
		wr_acc && is_off(paddr, `PFES_OFF_CTRL) && pwdata[`PFES_BIT_START]
			&& state == PFES_IDLE
			&& (key != 2'h2 || !pwdata[`PFES_BIT_WRITE_ENABLE_BIT]);
	endsequence

	chk_start_needs_key: assert property (
		s_refused_start |=> state == PFES_IDLE && !cpu_stall
			&& !regs.ctrl[`PFES_BIT_START] && !flash_erase && !flash_prog)
		else $error("start accepted without key or write enable");
	chk_stall_on_start: assert property (
		s_keyed_start ##1 (state != PFES_IDLE) |-> cpu_stall)
		else $error("cpu not stalled during cycle");
	chk_busy_stall: assert property (
		state != PFES_IDLE |-> cpu_stall)
		else $error("cpu not stalled while busy");
	chk_erase_len: assert property (
		$rose(state == PFES_ERASE) |-> (state == PFES_ERASE)[*8])
		else $error("erase ended early");
	chk_row_done: assert property (
		$rose(state == PFES_ROW) |-> ##[RW_LEN:RW_LEN]
			(state == PFES_IDLE && !regs.ctrl[`PFES_BIT_START]))
		else $error("start bit not cleared after row");
	chk_erase_done: assert property (
		$rose(state == PFES_ERASE) |-> ##[ER_LEN:ER_LEN]
			(state == PFES_IDLE && !regs.ctrl[`PFES_BIT_START]))
		else $error("start bit not cleared after erase");
	chk_erase_op: assert property (
		flash_erase |-> state == PFES_ERASE
			&& regs.ctrl[3:0] == `PFES_OP_ERASE
			&& regs.ctrl[`PFES_BIT_ERASE])
		else $error("erase with wrong operation code");
	chk_row_op: assert property (
		flash_prog |-> state == PFES_ROW
			&& regs.ctrl[3:0] == `PFES_OP_ROW
			&& !regs.ctrl[`PFES_BIT_ERASE])
		else $error("row program with wrong operation code");
	chk_row_words: assert property (
		flash_prog |=> flash_word_valid[*8])
		else $error("row words not streamed after start");
	chk_idle_unstall: assert property (
		state == PFES_IDLE && $past(state) == PFES_IDLE |-> !cpu_stall)
		else $error("stall held while idle");
endmodule // pfes_seq

//--- verif/tb.sv
`timescale 1ns/1ps
`include "pfes_consts.svh"
module tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, cpu_stall, flash_erase, flash_prog, slv;
	logic [7:0] flash_page;
	logic [15:0] flash_offs;
	logic [5:0] flash_word;
	logic flash_word_valid;
	logic [23:0] flash_wdata, w0, w1;
	int err_count = 0, samples_checked = 0, stall_n = 0, er_n = 0, pg_n = 0;
	int wv_n = 0;
	int s0, e0, p0, v0;
	always #50 pclk = ~pclk;
	pfes_seq i_pfes_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_stall(cpu_stall), .flash_erase(flash_erase),
		.flash_prog(flash_prog), .flash_page(flash_page),
		.flash_offs(flash_offs), .flash_word(flash_word),
		.flash_word_valid(flash_word_valid), .flash_wdata(flash_wdata));
	// Pulse and stall counters, read as differences around each test
	always @(posedge pclk) begin
		stall_n += (cpu_stall === 1'b1);
		er_n += (flash_erase === 1'b1);
		pg_n += (flash_prog === 1'b1);
		wv_n += (flash_word_valid === 1'b1);
		if (flash_word_valid === 1'b1 && flash_word === 6'h00) w0 = flash_wdata;
		if (flash_word_valid === 1'b1 && flash_word === 6'h3f) w1 = flash_wdata;
	end
	task finish_test;
		$display("Checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		slv = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 20) begin
			err_count++;
			finish_test;
		end
	endtask
	task go(input logic [31:0] c);
		apb(1, `PFES_OFF_KEY, 32'h55);
		apb(1, `PFES_OFF_KEY, 32'haa);
		apb(1, `PFES_OFF_CTRL, c);
	endtask
	// Poll completion; hardware alone clears the start bit
	task wait_done;
		int n;
		n = 0;
		do begin
			apb(0, `PFES_OFF_CTRL, 0);
			n++;
		end while (r[15] !== 1'b0 && n < 100);
		if (n >= 100) begin
			err_count++;
			finish_test;
		end
	endtask
	task snap;
		s0 = stall_n;
		e0 = er_n;
		p0 = pg_n;
		v0 = wv_n;
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		chk({31'h0, cpu_stall}, 0);
		apb(0, 12'h018, 0);
		chk({31'h0, slv}, 1);
		apb(1, 12'h018, 32'h1);
		chk({31'h0, slv}, 1);
		$display("Test reset and unmapped done");
		snap();
		apb(1, `PFES_OFF_CTRL, 32'hc001);
		apb(0, `PFES_OFF_CTRL, 0);
		chk(r & 32'hffff, 32'h4001);
		go(32'h8001);
		apb(0, `PFES_OFF_CTRL, 0);
		chk(r & 32'hffff, 32'h0001);
		apb(1, `PFES_OFF_KEY, 32'h55);
		apb(1, `PFES_OFF_PAGE, 32'h3);
		apb(1, `PFES_OFF_KEY, 32'haa);
		apb(1, `PFES_OFF_CTRL, 32'hc001);
		apb(0, `PFES_OFF_CTRL, 0);
		chk({31'h0, r[15]}, 0);
		go(32'hc041);
		wait_done();
		chk(stall_n - s0 + er_n - e0 + pg_n - p0, 0);
		$display("Test refused starts done");
		apb(1, `PFES_OFF_PAGE, 32'h5a);
		apb(1, `PFES_OFF_OFFS, 32'h0400);
		snap();
		go(32'hc042);
		apb(0, `PFES_OFF_STAT, 0);
		chk(r, 32'hc0);
		wait_done();
		chk(er_n - e0, 1);
		chk(pg_n - p0, 0);
		chk(stall_n - s0, `PFES_ERASE_CYC);
		chk(r & 32'hffff, 32'h4042);
		chk({flash_page, flash_offs}, 24'h5a0400);
		$display("Test erase done");
		for (int i = 0; i < 64; i++)
			apb(1, `PFES_OFF_DATA, 32'h00a500 + i);
		snap();
		go(32'hc001);
		wait_done();
		chk(pg_n - p0, 1);
		chk(er_n - e0, 0);
		chk(wv_n - v0, 64);
		chk(stall_n - s0, `PFES_ROW_CYC);
		chk(r & 32'hffff, 32'h4001);
		chk(w0, 24'h00a500);
		chk(w1, 24'h00a53f);
		repeat (2) apb(1, `PFES_OFF_CTRL, 32'hc001);
		apb(0, `PFES_OFF_CTRL, 0);
		chk({31'h0, r[15]}, 0);
		chk(stall_n - s0, `PFES_ROW_CYC);
		$display("Test row program done");
		finish_test;
	end
endmodule // tb
